// [logic/boundary_scan_test_port.sv]
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Test access port and state machine follow the standard boundary-scan behaviour.
// - Configuration data can be loaded through the test port pins.
// - Boundary test paths are blocked while configuration is in progress.
// - Sample/preload captures pin values and preloads a pattern, pins undisturbed.
// - External test drives the preloaded pattern out and captures input pins.
// - Bypass places a one-stage register between data-in and data-out.
// - User-signature readout shifts the user signature out on data-out.
// - Identification readout shifts the identification value out on data-out.
// - A single configuration-load instruction exists for in-circuit loading.
module boundary_scan_test_port
    import scan_port_pkg::*;
#(
    parameter int BSR_W = BSR_W_DEFAULT,
    parameter int CFG_W = CFG_W_DEFAULT,
    parameter logic [ID_W-1:0] IDCODE_VAL = IDCODE_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic config_busy,
    input wire logic [ID_W-1:0] user_signature,
    input wire logic [BSR_W-1:0] pin_in,
    input wire logic [BSR_W-1:0] core_out,
    output logic [BSR_W-1:0] pin_out,
    output logic extest_active,
    output logic [CFG_W-1:0] config_data,
    output logic config_strobe
);

    // ------------------------------------------------------------
    // Link synchronisers and edge detection
    // ------------------------------------------------------------
    link_pins_t link_q1, link_q2;
    logic tck_q3;
    logic busy_q1, busy_q2;
    logic [BSR_W-1:0] pin_q1, pin_q2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Start at the idle levels so no false clock edge follows reset
            link_q1 <= LINK_IDLE;
            link_q2 <= LINK_IDLE;
            tck_q3 <= LINK_IDLE.tck;
            busy_q1 <= 1'b0;
            busy_q2 <= 1'b0;
            pin_q1 <= '0;
            pin_q2 <= '0;
        end else begin
            link_q1 <= '{tck: tck, tms: tms, tdi: tdi};
            link_q2 <= link_q1;
            tck_q3 <= link_q2.tck;
            busy_q1 <= config_busy;
            busy_q2 <= busy_q1;
            pin_q1 <= pin_in;
            pin_q2 <= pin_q1;
        end
    end

    wire tck_rise = link_q2.tck & ~tck_q3;
    wire tck_fall = ~link_q2.tck & tck_q3;
    wire tms_s = link_q2.tms;
    wire tdi_s = link_q2.tdi;

    // ------------------------------------------------------------
    // Port state machine
    // ------------------------------------------------------------
    tap_state_t state, next_state;

    always_comb begin
        next_state = state;
        case (state)
            test_logic_reset: next_state = tms_s ? test_logic_reset : run_test_idle;
            run_test_idle: next_state = tms_s ? select_dr : run_test_idle;
            select_dr: next_state = tms_s ? select_ir : capture_dr;
            capture_dr: next_state = tms_s ? exit1_dr : shift_dr;
            shift_dr: next_state = tms_s ? exit1_dr : shift_dr;
            exit1_dr: next_state = tms_s ? update_dr : pause_dr;
            pause_dr: next_state = tms_s ? exit2_dr : pause_dr;
            exit2_dr: next_state = tms_s ? update_dr : shift_dr;
            update_dr: next_state = tms_s ? select_dr : run_test_idle;
            select_ir: next_state = tms_s ? test_logic_reset : capture_ir;
            capture_ir: next_state = tms_s ? exit1_ir : shift_ir;
            shift_ir: next_state = tms_s ? exit1_ir : shift_ir;
            exit1_ir: next_state = tms_s ? update_ir : pause_ir;
            pause_ir: next_state = tms_s ? exit2_ir : pause_ir;
            exit2_ir: next_state = tms_s ? update_ir : shift_ir;
            update_ir: next_state = tms_s ? select_dr : run_test_idle;
            default: next_state = test_logic_reset;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= test_logic_reset;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    logic [IR_W-1:0] ir, ir_shift;

    // Boundary paths fall back to bypass during configuration
    wire bsr_allowed = ~busy_q2;
    wire sel_bsr = ((ir == IR_SAMPLE) | (ir == IR_EXTEST)) & bsr_allowed;
    wire sel_id = (ir == IR_IDCODE);
    wire sel_ues = (ir == IR_USER_SIG);
    wire sel_cfg = (ir == IR_CFG_LOAD);
    wire sel_bypass = ~(sel_bsr | sel_id | sel_ues | sel_cfg);
    wire in_shift = (state == shift_dr) | (state == shift_ir);

    wire dr_capture = tck_rise & (state == capture_dr);
    wire dr_shift = tck_rise & (state == shift_dr);
    wire dr_update = tck_rise & (state == update_dr);

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir <= IR_IDCODE;
            ir_shift <= '0;
        end else if (state == test_logic_reset) begin
            ir <= IR_IDCODE;
        end else if (tck_rise) begin
            if (state == capture_ir)
                ir_shift <= IR_CAPTURE;
            else if (state == shift_ir)
                ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
            else if (state == update_ir)
                ir <= ir_shift;
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    logic [BSR_W-1:0] bsr_shift, bsr_update;
    logic [ID_W-1:0] id_shift;
    logic [CFG_W-1:0] cfg_shift;
    logic bypass_bit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_shift <= '0;
            bsr_update <= '0;
            id_shift <= '0;
            cfg_shift <= '0;
            bypass_bit <= 1'b0;
        end else begin
            if (dr_capture) begin
                bsr_shift <= pin_q2;
                id_shift <= sel_id ? IDCODE_VAL : user_signature;
                bypass_bit <= BYPASS_CAPTURE;
            end else if (dr_shift) begin
                if (sel_bsr)
                    bsr_shift <= {tdi_s, bsr_shift[BSR_W-1:1]};
                if (sel_id | sel_ues)
                    id_shift <= {tdi_s, id_shift[ID_W-1:1]};
                if (sel_cfg)
                    cfg_shift <= {tdi_s, cfg_shift[CFG_W-1:1]};
                bypass_bit <= tdi_s;
            end
            if (dr_update & sel_bsr)
                bsr_update <= bsr_shift;
        end
    end

    // ------------------------------------------------------------
    // Pin, configuration and serial outputs
    // ------------------------------------------------------------
    wire next_extest = (ir == IR_EXTEST) & bsr_allowed;
    wire dr_bit = sel_bsr ? bsr_shift[0] :
                  (sel_id | sel_ues) ? id_shift[0] :
                  sel_cfg ? cfg_shift[0] : bypass_bit;
    wire out_bit = (state == shift_ir) ? ir_shift[0] : dr_bit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extest_active <= 1'b0;
            pin_out <= '0;
            config_data <= '0;
            config_strobe <= 1'b0;
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            extest_active <= next_extest;
            // Normal operation passes core values to the pins through one clock register
            pin_out <= extest_active ? bsr_update : core_out;
            config_strobe <= dr_update & sel_cfg;
            if (dr_update & sel_cfg)
                config_data <= cfg_shift;
            if (tck_fall) begin
                tdo <= in_shift ? out_bit : 1'b0;
                tdo_oe <= in_shift;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_strobe_pulse;
        config_strobe ##1 !config_strobe;
    endsequence

    property p_oe_shift;
        tck_fall && in_shift |=> tdo_oe && tdo == $past(out_bit);
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("data-out not driven in shift");

    property p_oe_idle;
        tck_fall && !in_shift |=> !tdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data-out driven outside shift");

    property p_oe_hold;
        !tck_fall |=> tdo_oe == $past(tdo_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data-out enable moved off edge");

    property p_fsm_step;
        tck_rise && state == run_test_idle && tms_s |=> state == select_dr;
    endproperty
    a_fsm_step: assert property (p_fsm_step) else $error("state machine did not advance");

    property p_reset_ir;
        state == test_logic_reset |=> ir == IR_IDCODE;
    endproperty
    a_reset_ir: assert property (p_reset_ir) else $error("reset did not select id path");

    property p_id_capture;
        dr_capture && sel_id |=> id_shift == IDCODE_VAL;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id value not captured");

    property p_ues_capture;
        dr_capture && sel_ues |=> id_shift == $past(user_signature);
    endproperty
    a_ues_capture: assert property (p_ues_capture) else $error("signature not captured");

    property p_bypass;
        dr_shift && sel_bypass |=> bypass_bit == $past(tdi_s);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass stage broken");

    property p_extest_pins;
        extest_active |=> pin_out == $past(bsr_update);
    endproperty
    a_extest_pins: assert property (p_extest_pins) else $error("test pattern not driven");

    property p_normal_pins;
        !extest_active |=> pin_out == $past(core_out);
    endproperty
    a_normal_pins: assert property (p_normal_pins) else $error("pins disturbed in normal mode");

    property p_busy_blocks;
        busy_q2 |=> !extest_active;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("boundary test during config");

    property p_cfg_strobe;
        dr_update && sel_cfg |=> s_strobe_pulse;
    endproperty
    a_cfg_strobe: assert property (p_cfg_strobe) else $error("config strobe not one pulse");

endmodule // boundary_scan_test_port

`default_nettype wire

// [logic/scan_port_pkg.sv]
`default_nettype none
package scan_port_pkg;

    // ------------------------------------------------------------
    // Instruction register layout
    // ------------------------------------------------------------
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h5;
    localparam logic [IR_W-1:0] IR_USER_SIG = 4'h7;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h6;
    localparam logic [IR_W-1:0] IR_CFG_LOAD = 4'h2;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;

    // ------------------------------------------------------------
    // Data register widths and capture values
    // ------------------------------------------------------------
    localparam int ID_W = 32;
    // Arbitrary identification value, not tied to any real part
    localparam logic [ID_W-1:0] IDCODE_DEFAULT = 32'h0ABC_1235;
    localparam int BSR_W_DEFAULT = 8;
    localparam int CFG_W_DEFAULT = 8;
    localparam logic BYPASS_CAPTURE = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        test_logic_reset, run_test_idle,
        select_dr, capture_dr, shift_dr, exit1_dr, pause_dr, exit2_dr, update_dr,
        select_ir, capture_ir, shift_ir, exit1_ir, pause_ir, exit2_ir, update_ir
    } tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } link_pins_t;

    // Idle link levels: clock parked high, mode-select pulled high
    localparam link_pins_t LINK_IDLE = '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};

endpackage

`default_nettype wire

// [testbench/scan_controller_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_controller_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Link clock stands high between calls, so no edge appears outside frames
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 125 ns test-clock period; data-out is taken just before the rise
    task automatic step(input logic m, input logic d, output logic q, output logic oe);
        #62.5 tck = 1'b0;
        tms = m;
        tdi = d;
        #62.5 q = tdo;
        oe = tdo_oe;
        tck = 1'b1;
    endtask

    task automatic idle(input int n, input logic m);
        logic q;
        logic oe;
        for (int k = 0; k < n; k++) begin
            step(m, ~tdi, q, oe);
        end
        step(1'b0, ~tdi, q, oe);
    endtask

    // From run-test/idle through one register scan and back, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe_ok);
        logic q;
        logic oe;
        dout = '0;
        step(1'b1, ~din[0], q, oe);
        if (ir) begin
            step(1'b1, ~din[0], q, oe);
        end
        step(1'b0, ~din[0], q, oe);
        step(1'b0, ~din[0], q, oe);
        oe_ok = ~oe;
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], q, oe);
            dout[k] = q;
            oe_ok = oe_ok & oe;
        end
        step(1'b1, ~din[n-1], q, oe);
        oe_ok = oe_ok & ~oe;
        step(1'b0, ~din[n-1], q, oe);
        // Clock stays high while the update edge works through the synchronisers
        #125;
    endtask
endmodule // scan_controller_model
`default_nettype wire

// [testbench/test_boundary_scan_test_port.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_boundary_scan_test_port;
    import scan_port_pkg::*;
    logic clk;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic config_busy;
    logic [ID_W-1:0] user_signature;
    logic [7:0] pin_in;
    logic [7:0] core_out;
    logic [7:0] pin_out;
    logic extest_active;
    logic [7:0] config_data;
    logic config_strobe;
    logic [31:0] d;
    logic ok;
    int num_errors = 0;
    int checks_done = 0;
    int strobes = 0;
    localparam logic [ID_W-1:0] IDCODE_VAL_EXP = IDCODE_DEFAULT;

    always #5 clk = ~clk;
    always @(posedge clk) if (config_strobe === 1'b1) strobes++;

    scan_controller_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    boundary_scan_test_port dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .config_busy(config_busy),
        .user_signature(user_signature), .pin_in(pin_in), .core_out(core_out),
        .pin_out(pin_out), .extest_active(extest_active), .config_data(config_data),
        .config_strobe(config_strobe));

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic load_ir(input logic [IR_W-1:0] op);
        ctl.scan(1'b1, IR_W, 32'(op), d, ok);
        `CHK(d[IR_W-1:0], IR_CAPTURE)
    endtask

    task automatic test_idcode();
        ctl.scan(1'b0, 32, 32'h0, d, ok);
        `CHK(d, IDCODE_VAL_EXP)
        `CHK(ok, 1'b1)
        $display("test idcode done");
    endtask

    task automatic test_bypass();
        load_ir(IR_BYPASS);
        ctl.scan(1'b0, 4, 32'hB, d, ok);
        `CHK(d[3:0], 4'h6)
        $display("test bypass done");
    endtask

    task automatic test_user_sig();
        @(posedge clk) user_signature <= 32'h5A5A_C3C3;
        load_ir(IR_USER_SIG);
        ctl.scan(1'b0, 32, 32'h0, d, ok);
        `CHK(d, 32'h5A5A_C3C3)
        ctl.idle(5, 1'b1);
        ctl.scan(1'b0, 32, 32'h0, d, ok);
        `CHK(d, IDCODE_VAL_EXP)
        $display("test user signature done");
    endtask

    task automatic test_sample_extest();
        @(posedge clk) pin_in <= 8'hA6;
        core_out <= 8'h3C;
        load_ir(IR_SAMPLE);
        ctl.scan(1'b0, 8, 32'h81, d, ok);
        `CHK(d[7:0], 8'hA6)
        `CHK(pin_out, 8'h3C)
        `CHK(extest_active, 1'b0)
        load_ir(IR_EXTEST);
        `CHK(pin_out, 8'h81)
        `CHK(extest_active, 1'b1)
        @(posedge clk) pin_in <= 8'h59;
        ctl.scan(1'b0, 8, 32'h24, d, ok);
        `CHK(d[7:0], 8'h59)
        `CHK(pin_out, 8'h24)
        $display("test sample extest done");
    endtask

    task automatic test_busy();
        @(posedge clk) config_busy <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(extest_active, 1'b0)
        ctl.scan(1'b0, 4, 32'hB, d, ok);
        `CHK(d[3:0], 4'h6)
        @(posedge clk) config_busy <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(extest_active, 1'b1)
        $display("test busy done");
    endtask

    task automatic test_config();
        load_ir(IR_CFG_LOAD);
        strobes = 0;
        ctl.scan(1'b0, 8, 32'hC5, d, ok);
        `CHK(config_data, 8'hC5)
        `CHK(strobes, 1)
        `CHK(extest_active, 1'b0)
        $display("test config done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        config_busy = 1'b0;
        user_signature = '0;
        pin_in = 8'h00;
        core_out = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        ctl.idle(0, 1'b0);
        test_idcode();
        test_bypass();
        test_user_sig();
        test_sample_extest();
        test_busy();
        test_config();
        conclude();
    end

    // Whole sequence needs about 30 us; margin covers a stuck state machine
    initial begin
        #300000;
        num_errors++;
        conclude();
    end
endmodule // test_boundary_scan_test_port
`default_nettype wire
